// ===== host_bus_model.sv
// Purpose: host microcontroller model driving the register pins
// Assumes: strobes held low 8 cycles and high 8 cycles per access
// Notes: released address and data pins show the inverse of the last value
module host_bus_model
  import power_ready_pkg::*;
(
  input wire logic clk_i,
  output host_strobe_t strobe_o,
  output logic [4:0] addr_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    strobe_o = '1;
    addr_o = 5'h00;
    data_o = 16'h0000;
  end

  // ==================================================
  // one access, pins move at the falling edge
  // spacing longer than the remote wait keeps reads off a busy port
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data);
    @(negedge clk_i);
    addr_o = addr;
    if (wr) begin
      data_o = data;
    end
    strobe_o = {1'b0, wr, ~wr};
    repeat (8) @(negedge clk_i);
    strobe_o = '1;
    addr_o = ~addr;
    data_o = ~data_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ===== power_ready_ctrl.sv
// Purpose: power state control, power event pin and ready status for the host
// Assumes: host strobes arrive from outside, address and data stable while strobed
// Notes: reads of offsets owned by other blocks return zero here
// How it works
// - one full state, two saving states via register
// - listen state keeps clock, PHY, receive wake
// - per state clock gating of modules
// - deep sleep stops every clock and block
// - wake event in listen state clears mode, back to full
// - host wakeup write returns to full power
// - power event pin push-pull or open-drain
// - power event polarity selectable
// - pulse select gives one 60 ms pulse
// - otherwise event output held until cleared
// - wake kinds recorded in readable flags
// - mode write or flag clear releases output
// - device ready low in reset, saving, busy
// - read ready low until remote data ready
// - not-ready after remote read command or data port read
// - not-ready period at most 60 ns
// - back-to-back data port reads once ready
// - count write clears remote done flag
// - count decrements on each data access
// - done flag sets when count reaches zero
// - byte registers, data port 8 or 16
// - offsets 01h-0Fh banked in four pages
// - offset 17h reads status, writes jam limit
module power_ready_ctrl
  import power_ready_pkg::*;
#(
  parameter int PME_PULSE_CYC = PME_PULSE_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire host_strobe_t host_strobe_i,
  input wire logic [4:0] host_addr_i,
  input wire logic [15:0] host_data_i,
  output logic [15:0] host_data_o,
  output logic host_data_oe_n_o,
  input wire logic [WAKE_KINDS-1:0] wake_event_i,
  input wire logic eeprom_busy_i,
  input wire logic loopback_swap_i,
  input wire logic [15:0] rdma_data_i,
  output logic rdma_fetch_o,
  output logic port_width_o,
  output logic [7:0] jam_limit_o,
  output clock_gates_t gates_o,
  output logic restart_clocks_o,
  output logic pme_o,
  output logic pme_oe_n_o
);
  // ==================================================
  // strobe synchronisers
  host_strobe_t sync1_reg, sync2_reg, sync3_reg, pins_reg;
  logic wr_prev_reg, rd_prev_reg;
  wire host_strobe_t agree_w = ~(sync2_reg ^ sync3_reg);
  wire host_strobe_t pins_next = (sync3_reg & agree_w) | (pins_reg & ~agree_w);
  wire wr_act = ~pins_reg.cs_n & ~pins_reg.wr_n;
  wire rd_act = ~pins_reg.cs_n & ~pins_reg.rd_n;
  wire wr_start = wr_act & ~wr_prev_reg;
  wire rd_start = rd_act & ~rd_prev_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      pins_reg <= '1;
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= host_strobe_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= pins_next;
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
    end
  end

  // ==================================================
  // address decode
  logic [7:0] command_reg, data_config_reg, buffer_type_reg, power_mode_reg, jam_limit_reg;
  logic [WAKE_KINDS-1:0] wake_flags_reg;
  wire [1:0] page_w = command_reg[PAGE_LSB +: 2];
  wire banked_w = (host_addr_i != OFS_COMMAND) && (host_addr_i <= OFS_BANK_LAST);
  wire page0_w = !banked_w || (page_w == PAGE_ZERO);
  wire page3_w = banked_w && (page_w == PAGE_THREE);
  wire hit_command = host_addr_i == OFS_COMMAND;
  wire hit_count_low = page0_w && host_addr_i == OFS_COUNT_LOW;
  wire hit_count_high = page0_w && host_addr_i == OFS_COUNT_HIGH;
  wire hit_wake_status = page3_w && host_addr_i == OFS_WAKE_STATUS;
  wire hit_power_mode = page3_w && host_addr_i == OFS_POWER_MODE;
  wire hit_data_config = page0_w && host_addr_i == OFS_DATA_CONFIG;
  wire hit_data_port = host_addr_i[4:1] == OFS_DATA_PORT[4:1];
  wire hit_buffer_type = host_addr_i == OFS_BUFFER_TYPE;
  wire hit_state_flags = host_addr_i == OFS_STATE_FLAGS;
  wire hit_host_wakeup = host_addr_i == OFS_HOST_WAKEUP;
  wire wr_command = wr_start && hit_command;
  wire wr_count = wr_start && (hit_count_low || hit_count_high);
  wire wr_power_mode = wr_start && hit_power_mode;
  wire wr_wake_status = wr_start && hit_wake_status;
  wire dp_access = (wr_start || rd_start) && hit_data_port;
  wire dp_read = rd_start && hit_data_port;
  wire remote_read_cmd = wr_command && host_data_i[CMD_LSB +: 3] == CMD_REMOTE_READ;

  // ==================================================
  // control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      command_reg <= RESET_BYTE;
      data_config_reg <= RESET_BYTE;
      buffer_type_reg <= RESET_BYTE;
      jam_limit_reg <= RESET_BYTE;
    end else if (wr_start) begin
      if (hit_command) command_reg <= host_data_i[7:0];
      if (hit_data_config) data_config_reg <= host_data_i[7:0];
      if (hit_buffer_type) buffer_type_reg <= host_data_i[7:0];
      if (hit_state_flags) jam_limit_reg <= host_data_i[7:0];
    end
  end
  assign jam_limit_o = jam_limit_reg;
  assign port_width_o = data_config_reg[WIDTH_SEL_BIT];

  // ==================================================
  // power state
  power_state_t state_reg, state_next;
  wire wake_any = |wake_event_i;
  wire host_wake = wr_start && hit_host_wakeup && state_reg != FULL_POWER_STATE;
  wire rx_alive = state_reg != DEEP_SLEEP_STATE;
  wire wake_hit = wake_any && rx_alive;

  always_comb begin
    case (host_data_i[7:0])
      POWER_FULL: state_next = FULL_POWER_STATE;
      POWER_LISTEN: state_next = WAKE_LISTEN_STATE;
      POWER_DEEP: state_next = DEEP_SLEEP_STATE;
      default: state_next = state_reg;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= FULL_POWER_STATE;
      power_mode_reg <= POWER_FULL;
    end else if (host_wake || wake_hit) begin
      state_reg <= FULL_POWER_STATE;
      power_mode_reg <= POWER_FULL;
    end else if (wr_power_mode) begin
      state_reg <= state_next;
      power_mode_reg <= host_data_i[7:0];
    end
  end

  // clocks per state
  always_comb begin
    case (state_reg)
      FULL_POWER_STATE: gates_o = '1;
      WAKE_LISTEN_STATE: gates_o = '{internal_clk: 1'b1, mac_host_clk: 1'b0, pm_rx_clk: 1'b1, phy_clk: 1'b1};
      DEEP_SLEEP_STATE: gates_o = '0;
      default: gates_o = '1;
    endcase
  end
  // raw pins: the core clock is stopped in deep sleep
  assign restart_clocks_o = (state_reg == DEEP_SLEEP_STATE) && !host_strobe_i.cs_n && !host_strobe_i.wr_n
    && hit_host_wakeup;

  // ==================================================
  // wake flags and power event pin
  logic pme_active_reg;
  logic [PME_CNT_W-1:0] pme_cnt_reg;
  wire pulse_sel = buffer_type_reg[PULSE_SEL_BIT];
  wire flag_clear = wr_wake_status && |(host_data_i[WAKE_KINDS-1:0] & wake_flags_reg);
  wire clear_pme = wr_power_mode || flag_clear;
  wire pulse_done = pulse_sel && pme_cnt_reg == PME_CNT_W'(PME_PULSE_CYC - 1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_flags_reg <= '0;
    end else begin
      // new event beats a clear in the same cycle
      wake_flags_reg <= (wake_flags_reg & ~({WAKE_KINDS{wr_wake_status}} & host_data_i[WAKE_KINDS-1:0]))
        | (wake_event_i & {WAKE_KINDS{rx_alive}});
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pme_active_reg <= 1'b0;
      pme_cnt_reg <= '0;
    end else if (wake_hit) begin
      pme_active_reg <= 1'b1;
      pme_cnt_reg <= '0;
    end else if (clear_pme || pulse_done) begin
      pme_active_reg <= 1'b0;
      pme_cnt_reg <= '0;
    end else if (pme_active_reg && pulse_sel) begin
      pme_cnt_reg <= pme_cnt_reg + 1'b1;
    end
  end

  // push-pull drives both levels, open-drain only pulls low
  wire pme_level = pme_active_reg ? buffer_type_reg[POL_HIGH_BIT] : ~buffer_type_reg[POL_HIGH_BIT];
  assign pme_o = buffer_type_reg[OPEN_DRAIN_BIT] ? 1'b0 : pme_level;
  assign pme_oe_n_o = buffer_type_reg[OPEN_DRAIN_BIT] ? pme_level : 1'b0;

  // ==================================================
  // remote read readiness and byte count
  logic [15:0] count_reg, rd_data_reg;
  logic [RD_CNT_W-1:0] rd_wait_reg;
  logic rd_pending_reg, dma_done_reg, in_reset_reg;
  wire [15:0] step_w = port_width_o ? 16'h0002 : 16'h0001;
  wire [15:0] count_dec = count_reg > step_w ? count_reg - step_w : 16'h0000;
  wire fetch_start = remote_read_cmd || (dp_read && !rd_pending_reg);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pending_reg <= 1'b0;
      rd_wait_reg <= '0;
      rd_data_reg <= '0;
    end else if (fetch_start) begin
      rd_pending_reg <= 1'b1;
      rd_wait_reg <= RD_CNT_W'(RD_WAIT_CYC - 1);
    end else if (rd_pending_reg) begin
      if (rd_wait_reg == '0) begin
        rd_pending_reg <= 1'b0;
        rd_data_reg <= rdma_data_i;
      end else begin
        rd_wait_reg <= rd_wait_reg - 1'b1;
      end
    end
  end
  assign rdma_fetch_o = fetch_start;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= '0;
      dma_done_reg <= 1'b0;
    end else if (wr_count) begin
      if (hit_count_low) count_reg[7:0] <= host_data_i[7:0];
      else count_reg[15:8] <= host_data_i[7:0];
      dma_done_reg <= 1'b0;
    end else if (dp_access && count_reg != '0) begin
      count_reg <= count_dec;
      if (count_dec == '0) dma_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) in_reset_reg <= 1'b1;
    else in_reset_reg <= 1'b0;
  end

  // ==================================================
  // read path
  wire saving = state_reg != FULL_POWER_STATE;
  wire dev_ready = !(in_reset_reg || saving || eeprom_busy_i || loopback_swap_i);
  logic [7:0] state_flags_w;
  logic [15:0] read_mux_w;
  logic [15:0] host_data_reg;

  always_comb begin
    state_flags_w = '0;
    state_flags_w[DEV_RDY_BIT] = dev_ready;
    state_flags_w[RD_RDY_BIT] = !rd_pending_reg;
    state_flags_w[DMA_DONE_BIT] = dma_done_reg;
    read_mux_w = '0;
    if (hit_data_port) read_mux_w = port_width_o ? rd_data_reg : {8'h00, rd_data_reg[7:0]};
    else if (hit_command) read_mux_w[7:0] = command_reg;
    else if (hit_wake_status) read_mux_w[WAKE_KINDS-1:0] = wake_flags_reg;
    else if (hit_power_mode) read_mux_w[7:0] = power_mode_reg;
    else if (hit_buffer_type) read_mux_w[7:0] = buffer_type_reg;
    else if (hit_state_flags) read_mux_w[7:0] = state_flags_w;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) host_data_reg <= '0;
    else if (rd_start) host_data_reg <= read_mux_w;
  end
  assign host_data_o = host_data_reg;
  assign host_data_oe_n_o = !(rd_act && rd_prev_reg);

  // ==================================================
  // checks
  property p_deep_gates;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == DEEP_SLEEP_STATE |-> gates_o == '0;
  endproperty
  a_deep_gates: assert property (p_deep_gates) else $error("deep sleep clocks not stopped");

  property p_listen_gates;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == WAKE_LISTEN_STATE |-> gates_o.internal_clk && gates_o.phy_clk && gates_o.pm_rx_clk
        && !gates_o.mac_host_clk;
  endproperty
  a_listen_gates: assert property (p_listen_gates) else $error("listen gating wrong");

  property p_wake_return;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == WAKE_LISTEN_STATE && wake_any) |=> state_reg == FULL_POWER_STATE && power_mode_reg == POWER_FULL;
  endproperty
  a_wake_return: assert property (p_wake_return) else $error("wake event did not restore full power");

  property p_host_wake;
    @(posedge clk_i) disable iff (!reset_n_i)
      host_wake |=> state_reg == FULL_POWER_STATE;
  endproperty
  a_host_wake: assert property (p_host_wake) else $error("host wakeup ignored");

  property p_pme_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (pme_active_reg && !pulse_sel && !clear_pme) |=> pme_active_reg;
  endproperty
  a_pme_hold: assert property (p_pme_hold) else $error("held event output dropped");

  property p_pme_release;
    @(posedge clk_i) disable iff (!reset_n_i)
      (clear_pme && !wake_hit) |=> !pme_active_reg;
  endproperty
  a_pme_release: assert property (p_pme_release) else $error("event output not released");

  property p_count_clears_done;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_count |=> !dma_done_reg;
  endproperty
  a_count_clears_done: assert property (p_count_clears_done) else $error("done flag survived count write");

  property p_rd_bound;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(rd_pending_reg) |-> ##[1:6] !rd_pending_reg;
  endproperty
  a_rd_bound: assert property (p_rd_bound) else $error("read not ready too long");

  property p_saving_not_ready;
    @(posedge clk_i) disable iff (!reset_n_i)
      saving |-> !state_flags_w[DEV_RDY_BIT];
  endproperty
  a_saving_not_ready: assert property (p_saving_not_ready) else $error("ready shown while saving");

  property p_count_step;
    @(posedge clk_i) disable iff (!reset_n_i)
      (dp_access && !wr_count && count_reg > step_w) |=> count_reg == $past(count_reg) - $past(step_w);
  endproperty
  a_count_step: assert property (p_count_step) else $error("byte count not decremented");

  property p_zero_done;
    @(posedge clk_i) disable iff (!reset_n_i)
      (dp_access && !wr_count && count_reg != '0 && count_reg <= step_w) |=> dma_done_reg && count_reg == '0;
  endproperty
  a_zero_done: assert property (p_zero_done) else $error("done flag not set at zero");
endmodule

// ===== power_ready_pkg.sv
// Purpose: shared constants and carriers for the power and ready status block
// Assumes: 100 MHz core clock, 5-bit host register address, 16-bit data pins
// Notes: register field positions named here, logic uses only these names
package power_ready_pkg;
  // ==================================================
  // register offsets
  localparam logic [4:0] OFS_COMMAND = 5'h00;
  localparam logic [4:0] OFS_COUNT_LOW = 5'h0a;
  localparam logic [4:0] OFS_WAKE_STATUS = 5'h0a;
  localparam logic [4:0] OFS_COUNT_HIGH = 5'h0b;
  localparam logic [4:0] OFS_POWER_MODE = 5'h0b;
  localparam logic [4:0] OFS_DATA_CONFIG = 5'h0e;
  localparam logic [4:0] OFS_DATA_PORT = 5'h10;
  localparam logic [4:0] OFS_BUFFER_TYPE = 5'h15;
  localparam logic [4:0] OFS_STATE_FLAGS = 5'h17;
  localparam logic [4:0] OFS_HOST_WAKEUP = 5'h1f;
  localparam logic [4:0] OFS_BANK_LAST = 5'h0f;
  localparam logic [1:0] PAGE_ZERO = 2'h0;
  localparam logic [1:0] PAGE_THREE = 2'h3;
  // ==================================================
  // field positions and encodings
  localparam int PAGE_LSB = 6;
  localparam int CMD_LSB = 3;
  localparam logic [2:0] CMD_REMOTE_READ = 3'h1;
  localparam int WIDTH_SEL_BIT = 0;
  localparam int PULSE_SEL_BIT = 6;
  localparam int POL_HIGH_BIT = 5;
  localparam int OPEN_DRAIN_BIT = 4;
  localparam int DEV_RDY_BIT = 4;
  localparam int RD_RDY_BIT = 5;
  localparam int DMA_DONE_BIT = 6;
  localparam int WAKE_KINDS = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] POWER_FULL = 8'h00;
  localparam logic [7:0] POWER_LISTEN = 8'h01;
  localparam logic [7:0] POWER_DEEP = 8'h02;
  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RD_WAIT_NS = 60;
  localparam int RD_WAIT_CYC = (RD_WAIT_NS / CLK_PERIOD_NS) < 1 ? 1 : RD_WAIT_NS / CLK_PERIOD_NS;
  localparam int PME_PULSE_MS = 60;
  localparam int PME_PULSE_CYC_DEF = PME_PULSE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int PME_CNT_W = 23;
  localparam int RD_CNT_W = 4;
  // ==================================================
  // types
  typedef enum logic [1:0] {
    FULL_POWER_STATE = 2'b00,
    WAKE_LISTEN_STATE = 2'b01,
    DEEP_SLEEP_STATE = 2'b10
  } power_state_t;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } host_strobe_t;
  typedef struct packed {
    logic internal_clk;
    logic mac_host_clk;
    logic pm_rx_clk;
    logic phy_clk;
  } clock_gates_t;
endpackage

// ===== power_state_and_ready_status_tb_top.sv
// Purpose: self-checking bench for the power and ready status block
// Assumes: pulse length shortened to 20 cycles
// Notes: reads note their expected word, a monitor compares on data enable
module power_state_and_ready_status_tb_top
  import power_ready_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PULSE = 20;
  logic clk_i = 1'b0;
  logic reset_n_i;
  host_strobe_t strobe;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, rdma_data;
  logic oe_n, oe_d = 1'b1, fetch, width, power_event_out, pme_oe_n, restart, restart_seen;
  logic busy_eep, swap;
  logic [7:0] jam, jam_v;
  logic [2:0] wake;
  clock_gates_t gates;
  logic [15:0] exp_q[$];
  int error_cnt, checks, seed, fetch_cnt;

  power_ready_ctrl #(.PME_PULSE_CYC(PULSE)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .host_strobe_i(strobe), .host_addr_i(addr),
    .host_data_i(wdata), .host_data_o(rdata), .host_data_oe_n_o(oe_n), .wake_event_i(wake),
    .eeprom_busy_i(busy_eep), .loopback_swap_i(swap), .rdma_data_i(rdma_data),
    .rdma_fetch_o(fetch), .port_width_o(width), .jam_limit_o(jam), .gates_o(gates),
    .restart_clocks_o(restart), .pme_o(power_event_out), .pme_oe_n_o(pme_oe_n));

  host_bus_model host (.clk_i(clk_i), .strobe_o(strobe), .addr_o(addr), .data_o(wdata));

  always #5 clk_i = ~clk_i;

  // ==================================================
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 16'h0000);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.access(1'b1, a, {8'h00, d});
  endtask

  // ==================================================
  // monitors: read data, buffer side, restart request
  always @(negedge clk_i) begin
    oe_d <= oe_n;
    if (oe_d === 1'b1 && oe_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("FAIL at %0t: seen %h expected none", $time, rdata);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
    if (fetch === 1'b1) begin
      fetch_cnt++;
      rdma_data <= 16'($random(seed));
    end
    if (restart === 1'b1) begin
      restart_seen = 1'b1;
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    results();
  end

  // ==================================================
  // main sequence
  initial begin
    seed = 84705;
    reset_n_i = 1'b0;
    wake = 3'h0;
    busy_eep = 1'b0;
    swap = 1'b0;
    rdma_data = 16'($random(seed));
    repeat (2) @(negedge clk_i);
    check({12'h000, gates}, 16'h000f);
    check({14'h0000, power_event_out, pme_oe_n}, 16'h0002);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rd(OFS_STATE_FLAGS, 16'h0030);
    rd(OFS_COUNT_LOW, 16'h0000);
    jam_v = 8'($random(seed));
    wr(OFS_STATE_FLAGS, jam_v);
    check({8'h00, jam}, {8'h00, jam_v});
    for (int w = 0; w < 2; w++) begin
      wr(OFS_COMMAND, 8'h00);
      wr(OFS_DATA_CONFIG, 8'(w));
      check({15'h0000, width}, 16'(w));
      wr(OFS_COUNT_LOW, 8'(2 << w));
      wr(OFS_COUNT_HIGH, 8'h00);
      rd(OFS_STATE_FLAGS, 16'h0030);
      wr(OFS_COMMAND, 8'h08);
      rd(OFS_DATA_PORT, (w == 1) ? rdma_data : {8'h00, rdma_data[7:0]});
      rd(OFS_STATE_FLAGS, 16'h0030);
      rd(5'h11, (w == 1) ? rdma_data : {8'h00, rdma_data[7:0]});
      rd(OFS_STATE_FLAGS, 16'h0070);
    end
    wr(OFS_COMMAND, 8'hc0);
    wr(OFS_POWER_MODE, 8'h04);
    rd(OFS_POWER_MODE, 16'h0004);
    wr(OFS_COMMAND, 8'h40);
    rd(OFS_POWER_MODE, 16'h0000);
    wr(OFS_COMMAND, 8'hc0);
    wr(OFS_BUFFER_TYPE, 8'h20);
    check({14'h0000, power_event_out, pme_oe_n}, 16'h0000);
    for (int m = 1; m < 3; m++) begin
      wr(OFS_POWER_MODE, 8'(m));
      check({12'h000, gates}, (m == 1) ? 16'h000b : 16'h0000);
      if (m == 1) begin
        rd(OFS_STATE_FLAGS, 16'h0060);
      end
      restart_seen = 1'b0;
      wr(OFS_HOST_WAKEUP, 8'h00);
      check({15'h0000, restart_seen}, 16'(m - 1));
      check({12'h000, gates}, 16'h000f);
    end
    for (int k = 0; k < WAKE_KINDS; k++) begin
      wr(OFS_POWER_MODE, 8'h01);
      wake = 3'(1 << k);
      @(negedge clk_i);
      wake = 3'h0;
      @(negedge clk_i);
      check({12'h000, gates}, 16'h000f);
      check({14'h0000, power_event_out, pme_oe_n}, 16'h0002);
      rd(OFS_POWER_MODE, 16'h0000);
      rd(OFS_WAKE_STATUS, 16'(1 << k));
      if (k == 1) begin
        wr(OFS_POWER_MODE, 8'h00);
      end else begin
        wr(OFS_WAKE_STATUS, 8'(1 << k));
      end
      check({14'h0000, power_event_out, pme_oe_n}, 16'h0000);
      wr(OFS_WAKE_STATUS, 8'(1 << k));
    end
    wr(OFS_BUFFER_TYPE, 8'h50);
    check({15'h0000, pme_oe_n}, 16'h0001);
    wake = 3'h4;
    @(negedge clk_i);
    wake = 3'h0;
    repeat (PULSE - 4) @(negedge clk_i);
    check({14'h0000, power_event_out, pme_oe_n}, 16'h0000);
    repeat (8) @(negedge clk_i);
    check({15'h0000, pme_oe_n}, 16'h0001);
    wr(OFS_WAKE_STATUS, 8'h04);
    for (int b = 0; b < 2; b++) begin
      {swap, busy_eep} = 2'(1 << b);
      rd(OFS_STATE_FLAGS, 16'h0060);
    end
    {swap, busy_eep} = 2'b00;
    rd(OFS_STATE_FLAGS, 16'h0070);
    check(16'(fetch_cnt), 16'h0006);
    check(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule
